// [pdc_pkg.sv]
// Purpose: Shared constants and types for the count-pulse converter link
// Assumes: One 10 MHz system clock on both ends
// Notes: Position is kept as packed BCD digits
package pdc_pkg;
    // ==========================================================
    // Counting
    localparam int COUNTS_PER_REV = 4000;
    localparam int REV_DIGITS = 4;
    localparam int TURN_DIGITS = 4;
    localparam logic [3:0] BCD_MAX = 4'h9;
    localparam logic [3:0] BCD_ZERO = 4'h0;
    localparam logic [3:0] BCD_ONE = 4'h1;
    localparam logic [3:0] REV_TOP_DIGIT = 4'h3;
    // ==========================================================
    // Timing
    localparam int CLK_HZ = 10_000_000;
    localparam int MAX_REV_PER_S = 100;
    // Shortest spacing between count pulses at full tracking rate
    localparam int PULSE_GAP_CYC = CLK_HZ / (MAX_REV_PER_S * COUNTS_PER_REV);
    // Low time of one count pulse, kept well under the gap
    localparam int PULSE_LOW_CYC = PULSE_GAP_CYC / 2;
    localparam int SYNC_STAGES = 3;
    // ==========================================================
    // Types
    typedef enum logic {DIR_FWD, DIR_REV} dir_t;
endpackage : pdc_pkg

// [pdc_link_if.sv]
// Purpose: Pins between the converter and the position counter
// Assumes: All pins are plain one-way logic levels
// Notes: Count and zero pulses are active low
`timescale 1ns/1ps
interface pdc_link_if;
    logic countN;
    logic dirRev;
    logic zeroN;
    modport conv (output countN, output dirRev, output zeroN);
    modport cnt (input countN, input dirRev, input zeroN);
endinterface : pdc_link_if

// [resolver_pulse_gen.sv]
// Purpose: Converter end: turns position steps into count pulses
// Assumes: stepReq comes from the tracking loop on sys_clk
// Notes: Steps arriving while a pulse is pending are dropped
`timescale 1ns/1ps
module resolver_pulse_gen (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Tracking loop side
    input wire logic stepReq,
    input wire pdc_pkg::dir_t stepDir,
    output logic busy,
    // Link
    pdc_link_if.conv link
);
    import pdc_pkg::*;
    localparam logic [11:0] LAST_ANGLE = 12'(COUNTS_PER_REV - 1);
    localparam logic [7:0] LOW_CNT = 8'(PULSE_LOW_CYC);
    localparam logic [7:0] GAP_CNT = 8'(PULSE_GAP_CYC);
    logic [11:0] angle_r, angle_nxt;
    logic [7:0] tmr_r, tmr_nxt;
    logic countN_r, countN_nxt;
    logic zeroN_r, zeroN_nxt;
    logic dir_r, dir_nxt;
    logic busy_r, busy_nxt;
    // ==========================================================
    // Pulse timing
    always_comb begin
        angle_nxt = angle_r;
        tmr_nxt = tmr_r;
        countN_nxt = countN_r;
        zeroN_nxt = zeroN_r;
        dir_nxt = dir_r;
        busy_nxt = busy_r;
        if (busy_r) begin
            tmr_nxt = tmr_r - 8'h01;
            // Release after exactly the low count of cycles
            if (tmr_r == GAP_CNT - LOW_CNT + 8'h01) begin
                countN_nxt = 1'b1;
                zeroN_nxt = 1'b1;
            end
            if (tmr_r == 8'h01)
                busy_nxt = 1'b0;
        end else if (stepReq) begin
            // Direction settles with the falling edge of the pulse
            dir_nxt = (stepDir == DIR_REV);
            countN_nxt = 1'b0;
            busy_nxt = 1'b1;
            tmr_nxt = GAP_CNT;
            if (stepDir == DIR_FWD) begin
                angle_nxt = (angle_r == LAST_ANGLE) ? 12'h000 :
                    angle_r + 12'h001;
                zeroN_nxt = !(angle_r == LAST_ANGLE);
            end else begin
                angle_nxt = (angle_r == 12'h000) ? LAST_ANGLE :
                    angle_r - 12'h001;
                // Zero pulse rides the count that lands on angle zero
                zeroN_nxt = !(angle_r == 12'h001);
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            angle_r <= 12'h000;
            tmr_r <= 8'h00;
            countN_r <= 1'b1;
            zeroN_r <= 1'b1;
            dir_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            angle_r <= angle_nxt;
            tmr_r <= tmr_nxt;
            countN_r <= countN_nxt;
            zeroN_r <= zeroN_nxt;
            dir_r <= dir_nxt;
            busy_r <= busy_nxt;
        end
    end
    assign link.countN = countN_r;
    assign link.zeroN = zeroN_r;
    assign link.dirRev = dir_r;
    assign busy = busy_r;
endmodule : resolver_pulse_gen

// [bcd_position_counter.sv]
// Operation
// - One low count pulse per increment, 4000/rev
// - Direction level shows the motion sense
// - One zero pulse per zero crossing
// - Tracks continuously up to 100 revs per second; converter end pulses at most every 26 cycles, about 96 revs per second
// - Datum armed clears counters at next zero
// - Revolution chain holds all 4000 counts
// - Extra stages accumulate whole revolutions
// - Position held in BCD form
// - Datum exact to one count
//
// Purpose: Counter end: BCD position from count and zero pulses
// Assumes: Link pins are asynchronous to sys_clk
// Notes: Turn count wraps modulo its decimal range
`timescale 1ns/1ps
module bcd_position_counter #(
    parameter int REV_DIG = pdc_pkg::REV_DIGITS,
    parameter int TURN_DIG = pdc_pkg::TURN_DIGITS
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Operator
    input wire logic setDatum,
    // Readout
    output logic [4*REV_DIG-1:0] revPos,
    output logic [4*TURN_DIG-1:0] turnPos,
    output logic datumArmed,
    // Link
    pdc_link_if.cnt link
);
    import pdc_pkg::*;
    localparam int SN = SYNC_STAGES;
    logic [SN-1:0] cntSync_r, cntSync_nxt;
    logic [SN-1:0] dirSync_r, dirSync_nxt;
    logic [SN-1:0] zeroSync_r, zeroSync_nxt;
    logic [SN-1:0] armSync_r, armSync_nxt;
    logic cntLvl_r, cntLvl_nxt;
    logic dirLvl_r, dirLvl_nxt;
    logic zeroLvl_r, zeroLvl_nxt;
    logic armLvl_r, armLvl_nxt;
    logic [4*REV_DIG-1:0] rev_r, rev_nxt;
    logic [4*TURN_DIG-1:0] turn_r, turn_nxt;
    logic armed_r, armed_nxt;
    logic cntFall, zeroFall, armRise;
    logic revWrap;
    logic [3:0] d;
    // ==========================================================
    // Decade step helpers
    function automatic logic [4*REV_DIG-1:0] revStep(
        input logic [4*REV_DIG-1:0] v, input logic down, output logic wrap);
        logic [4*REV_DIG-1:0] r;
        logic go;
        logic [3:0] dg;
        r = v;
        go = 1'b1;
        wrap = 1'b0;
        // Top digit limited so the chain spans 0..3999
        if (!down && v == {REV_TOP_DIGIT, {(REV_DIG-1){BCD_MAX}}}) begin
            r = '0;
            wrap = 1'b1;
            go = 1'b0;
        end else if (down && v == '0) begin
            r = {REV_TOP_DIGIT, {(REV_DIG-1){BCD_MAX}}};
            wrap = 1'b1;
            go = 1'b0;
        end
        for (int i = 0; i < REV_DIG; i++) begin
            dg = v[4*i +: 4];
            if (go) begin
                if (!down) begin
                    r[4*i +: 4] = (dg == BCD_MAX) ? BCD_ZERO : dg + BCD_ONE;
                    go = (dg == BCD_MAX);
                end else begin
                    r[4*i +: 4] = (dg == BCD_ZERO) ? BCD_MAX : dg - BCD_ONE;
                    go = (dg == BCD_ZERO);
                end
            end
        end
        return r;
    endfunction : revStep
    function automatic logic [4*TURN_DIG-1:0] turnStep(
        input logic [4*TURN_DIG-1:0] v, input logic down);
        logic [4*TURN_DIG-1:0] r;
        logic go;
        logic [3:0] dg;
        r = v;
        go = 1'b1;
        for (int i = 0; i < TURN_DIG; i++) begin
            dg = v[4*i +: 4];
            if (go) begin
                if (!down) begin
                    r[4*i +: 4] = (dg == BCD_MAX) ? BCD_ZERO : dg + BCD_ONE;
                    go = (dg == BCD_MAX);
                end else begin
                    r[4*i +: 4] = (dg == BCD_ZERO) ? BCD_MAX : dg - BCD_ONE;
                    go = (dg == BCD_ZERO);
                end
            end
        end
        return r;
    endfunction : turnStep
    // ==========================================================
    // Input synchronisers, three stages, change when last two agree
    always_comb begin
        cntSync_nxt = {cntSync_r[SN-2:0], link.countN};
        dirSync_nxt = {dirSync_r[SN-2:0], link.dirRev};
        zeroSync_nxt = {zeroSync_r[SN-2:0], link.zeroN};
        armSync_nxt = {armSync_r[SN-2:0], setDatum};
        cntLvl_nxt = (cntSync_r[SN-1] == cntSync_r[SN-2]) ?
            cntSync_r[SN-1] : cntLvl_r;
        dirLvl_nxt = (dirSync_r[SN-1] == dirSync_r[SN-2]) ?
            dirSync_r[SN-1] : dirLvl_r;
        zeroLvl_nxt = (zeroSync_r[SN-1] == zeroSync_r[SN-2]) ?
            zeroSync_r[SN-1] : zeroLvl_r;
        armLvl_nxt = (armSync_r[SN-1] == armSync_r[SN-2]) ?
            armSync_r[SN-1] : armLvl_r;
    end
    // Filtered level edges fire once per pulse
    assign cntFall = cntLvl_r && !cntLvl_nxt;
    assign zeroFall = zeroLvl_r && !zeroLvl_nxt;
    assign armRise = !armLvl_r && armLvl_nxt;
    // ==========================================================
    // Position counting
    always_comb begin
        rev_nxt = rev_r;
        turn_nxt = turn_r;
        armed_nxt = armed_r;
        revWrap = 1'b0;
        d = BCD_ZERO;
        if (armRise)
            armed_nxt = 1'b1;
        if (cntFall) begin
            // Zero pulse falls with its count pulse
            rev_nxt = revStep(rev_r, dirLvl_nxt, revWrap);
            if (revWrap)
                turn_nxt = turnStep(turn_r, dirLvl_nxt);
        end
        if (zeroFall && armed_r) begin
            // Datum lands on the zero count itself
            rev_nxt = '0;
            turn_nxt = '0;
            armed_nxt = armRise;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            cntSync_r <= '1;
            dirSync_r <= '0;
            zeroSync_r <= '1;
            armSync_r <= '0;
            cntLvl_r <= 1'b1;
            dirLvl_r <= 1'b0;
            zeroLvl_r <= 1'b1;
            armLvl_r <= 1'b0;
            rev_r <= '0;
            turn_r <= '0;
            armed_r <= 1'b0;
        end else begin
            cntSync_r <= cntSync_nxt;
            dirSync_r <= dirSync_nxt;
            zeroSync_r <= zeroSync_nxt;
            armSync_r <= armSync_nxt;
            cntLvl_r <= cntLvl_nxt;
            dirLvl_r <= dirLvl_nxt;
            zeroLvl_r <= zeroLvl_nxt;
            armLvl_r <= armLvl_nxt;
            rev_r <= rev_nxt;
            turn_r <= turn_nxt;
            armed_r <= armed_nxt;
        end
    end
    assign revPos = rev_r;
    assign turnPos = turn_r;
    assign datumArmed = armed_r;
endmodule : bcd_position_counter

// [pdc_link_monitor.sv]
// Purpose: Watches the converter link pins between the two ends
// Assumes: One clock; link pins driven by the converter end
// Notes: Tracks angle from the pulses to judge the zero pulse
`timescale 1ns/1ps
module pdc_link_monitor (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Link
    input wire logic countN,
    input wire logic dirRev,
    input wire logic zeroN
);
    import pdc_pkg::*;
    logic prev_r, prev_nxt, fall;
    int ang_r, ang_nxt;
    // ========================================
    // Angle seen on the wire
    always_comb begin
        fall = prev_r && !countN;
        prev_nxt = countN;
        ang_nxt = ang_r;
        if (fall && dirRev)
            ang_nxt = (ang_r == 0) ? COUNTS_PER_REV - 1 : ang_r - 1;
        else if (fall)
            ang_nxt = (ang_r + 1) % COUNTS_PER_REV;
    end
    always_ff @(posedge sys_clk) begin
        prev_r <= resetn ? prev_nxt : 1'b1;
        ang_r <= resetn ? ang_nxt : 0;
    end
    // ========================================
    // Checks
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    a_reset_idle: assert property (
        $rose(resetn) |-> countN && zeroN && !dirRev)
        else $error("link not idle after reset");
    a_pulse_low_time: assert property ($fell(countN) |->
        !countN[*8] ##1 !countN[*4] ##1 countN)
        else $error("count pulse low time wrong");
    a_pulse_gap_min: assert property ($rose(countN) |->
        countN[*8] ##1 countN[*6])
        else $error("count pulse gap too short");
    a_count_rate: assert property (
        $fell(countN) |=> !$fell(countN)[*8]
        ##1 !$fell(countN)[*8] ##1 !$fell(countN)[*8])
        else $error("count pulses too fast");
    a_dir_only_fall: assert property (
        $changed(dirRev) |-> $fell(countN))
        else $error("direction moved outside pulse start");
    a_zero_at_origin: assert property (
        fall |-> zeroN != (ang_nxt == 0))
        else $error("zero pulse not at angle zero");
    a_no_stray_zero: assert property (!zeroN |-> !countN)
        else $error("zero pulse without count pulse");
    a_zero_len_match: assert property ($fell(zeroN) |-> $fell(countN)
        ##11 (!zeroN && !countN) ##1 (zeroN && countN))
        else $error("zero pulse not aligned to count");
    c_fwd: cover property (fall && !dirRev);
    c_rev: cover property (fall && dirRev);
    c_zero: cover property (fall && !zeroN);
endmodule : pdc_link_monitor

// [testbench.sv]
// Purpose: Drives steps and datum, checks BCD position and pins
// Assumes: Both ends share sys_clk at 10 MHz
// Notes: Each step holds its request 4 cycles into busy to exercise refusal
`timescale 1ns/1ps
module testbench;
    import pdc_pkg::*;
    localparam int TURNS = 10 ** TURN_DIGITS;
    logic sys_clk = 0, resetn = 0, stepReq = 0, setDatum = 0;
    dir_t stepDir = DIR_FWD;
    logic busy, datumArmed;
    logic [15:0] revPos, turnPos;
    int err_count = 0, total_checks = 0, ang = 0, trn = 0, cyc = 0;
    bit armed = 0;
    logic [31:0] expQ[$];
    logic [31:0] seen = '0;
    pdc_link_if lnk();
    resolver_pulse_gen i_resolver_pulse_gen (.sys_clk(sys_clk),
        .resetn(resetn), .stepReq(stepReq), .stepDir(stepDir),
        .busy(busy), .link(lnk.conv));
    bcd_position_counter i_bcd_position_counter (.sys_clk(sys_clk),
        .resetn(resetn), .setDatum(setDatum), .revPos(revPos),
        .turnPos(turnPos), .datumArmed(datumArmed), .link(lnk.cnt));
    pdc_link_monitor i_pdc_link_monitor (.sys_clk(sys_clk), .resetn(resetn),
        .countN(lnk.countN), .dirRev(lnk.dirRev), .zeroN(lnk.zeroN));
    initial forever #50 sys_clk = ~sys_clk;
    function automatic logic [15:0] bcd(int v);
        return {4'(v / 1000), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
    endfunction : bcd
    task automatic check(logic [31:0] got, logic [31:0] exp, string what);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    task automatic step(dir_t d);
        bit z;
        int n = 0;
        while (busy !== 1'b0 && n < 100) begin
            @(negedge sys_clk);
            n++;
        end
        check(datumArmed, armed, "armed");
        if (d == DIR_FWD) begin
            ang = (ang + 1) % COUNTS_PER_REV;
            trn = (ang == 0) ? (trn + 1) % TURNS : trn;
        end else begin
            trn = (ang == 0) ? (trn + TURNS - 1) % TURNS : trn;
            ang = (ang + COUNTS_PER_REV - 1) % COUNTS_PER_REV;
        end
        z = (ang == 0);
        if (z && armed) begin
            trn = 0;
            armed = 0;
        end
        expQ.push_back({bcd(trn), bcd(ang)});
        stepDir = d;
        stepReq = 1;
        @(negedge sys_clk);
        check({lnk.countN, lnk.dirRev, lnk.zeroN}, {1'b0, d, !z},
            "pins");
        repeat (4) @(negedge sys_clk);
        stepReq = 0;
    endtask : step
    // Position results arrive a few cycles after each pulse
    always @(negedge sys_clk) begin
        cyc++;
        if (cyc > 20000) begin
            err_count++;
            stop_test();
        end
        if (resetn && {turnPos, revPos} !== seen) begin
            seen = {turnPos, revPos};
            if (expQ.size() == 0)
                check(seen, '1, "extra");
            else
                check(seen, expQ.pop_front(), "pos");
        end
    end
    initial begin
        void'($urandom(66547));
        repeat (6) @(negedge sys_clk);
        check({busy, datumArmed}, '0, "reset flags");
        check({turnPos, revPos}, '0, "reset pos");
        resetn = 1;
        for (int i = 0; i < 24; i++)
            step(dir_t'($urandom_range(0, 1)));
        while (ang != 0)
            step(ang < 2000 ? DIR_REV : DIR_FWD);
        repeat (3) step(DIR_REV);
        repeat (5) step(DIR_FWD);
        setDatum = 1;
        repeat (8) @(negedge sys_clk);
        setDatum = 0;
        repeat (6) @(negedge sys_clk);
        armed = 1;
        repeat (4) step(DIR_FWD);
        repeat (9) step(DIR_REV);
        step(DIR_FWD);
        repeat (40) @(negedge sys_clk);
        check(expQ.size(), 0, "queue");
        stop_test();
    end
endmodule : testbench
